/* File: peripheral_irq_request_logic_test.sv */
// peripheral_irq_request_logic_test: self-checking bench for pirq_top
// assumes pirq_top, its checker and the core model are compiled first
`timescale 1ns/1ns
`define C(g, x) begin cmp_count++; if ((g) !== (x)) begin fails++; \
$display("unexpected t=%0t got %h exp %h", $time, g, x); end end
module peripheral_irq_request_logic_test;
    logic core_clk, rst_n, ovf_set, rx_set, tx_set, sof, sus;
    logic ca_irq, ser_irq, fn_irq, sof_irq, sus_irq, irq;
    logic [4:0] mod_set;
    logic [15:0] seed;
    logic [7:0] fl;
    logic [25:0] tab [15];
    logic [8:0] expq [$];
    logic [8:0] exp_v;
    pirq_pkg::pirq_apb_req_t req;
    pirq_pkg::pirq_apb_rsp_t rsp;
    pirq_pkg::pirq_usb_evt_t evt;
    int fails, cmp_count, cyc, vec_count, k;

    pirq_top DUT (.core_clk(core_clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
        .module_event_set(mod_set), .counter_overflow_set(ovf_set), .rx_complete_set(rx_set),
        .tx_complete_set(tx_set), .usb_evt(evt), .sof_pending(sof),
        .suspend_resume_pending(sus), .counter_array_irq(ca_irq), .serial_irq(ser_irq),
        .usb_function_irq(fn_irq), .usb_sof_irq(sof_irq), .usb_suspend_irq(sus_irq), .irq(irq));
    pirq_core_model core (.core_clk(core_clk), .rst_n(rst_n), .irq(irq), .vectors(vec_count));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // one bus transfer; held until the pready edge, one idle cycle between
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge core_clk);
        req <= '{1'b1, 1'b0, w, {2'b00, idx, 2'b00}, {24'h00_0000, d}};
        @(posedge core_clk);
        req.penable <= 1'b1;
        // no wait count assumed; a hang is caught by the cycle ceiling
        do
            @(posedge core_clk);
        while (!rsp.pready);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [8:0] x);
        expq.push_back(x);
        apb(1'b0, idx, 8'h00);
    endtask

    task automatic fire(input logic [7:0] v, input pirq_pkg::pirq_usb_evt_t u);
        @(posedge core_clk);
        {ovf_set, mod_set, rx_set, tx_set} <= v;
        evt <= u;
        @(posedge core_clk);
        {ovf_set, mod_set, rx_set, tx_set} <= 8'h00;
        evt <= '0;
        settle(3);
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        // pop once; the compare macro names its expected value twice
        if (req.psel && req.penable && rsp.pready && !req.pwrite)
        begin
            exp_v = expq.pop_front();
            `C({rsp.pslverr, rsp.prdata[7:0]}, exp_v)
        end
        cyc++;
        if (cyc == 6000)
        begin
            fails++;
            complete_run();
        end
    end

    initial
    begin
        rst_n = 1'b0;
        req = '0;
        {ovf_set, mod_set, rx_set, tx_set} = 8'h00;
        evt = '0;
        {sof, sus} = 2'b00;
        seed = lfsr(16'h1d84);
        // control, event {done tok ep rcvd tmo seq loaded ack}, expected flags
        tab = '{{8'h1b, 10'h310, 8'h02}, {8'h1f, 10'h310, 8'h00}, {8'h1f, 10'h290, 8'h02},
            {8'h19, 10'h310, 8'h00}, {8'h1b, 10'h314, 8'h00}, {8'h1b, 10'h318, 8'h00},
            {8'h5b, 10'h310, 8'h00}, {8'h1b, 10'h383, 8'h01}, {8'h1b, 10'h38a, 8'h01},
            {8'h1b, 10'h382, 8'h00}, {8'h3b, 10'h383, 8'h00}, {8'h0b, 10'h383, 8'h00},
            {8'h5b, 10'h383, 8'h00}, {8'h1a, 10'h290, 8'h00}, {8'h13, 10'h383, 8'h00}};
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        settle(0);
        `C({ca_irq, ser_irq, fn_irq, irq}, 4'h0)
        rd(pirq_pkg::IDX_EP_IRQ_EN, 9'h000);
        rd(pirq_pkg::IDX_EP_IRQ_FLAGS, 9'h000);
        rd(8'hff, 9'h100);
        wr(pirq_pkg::IDX_EP_IRQ_EN, seed[7:0]);
        rd(pirq_pkg::IDX_EP_IRQ_EN, {1'b0, seed[7:0]});
        wr(pirq_pkg::IDX_IRQ_EN_ZERO, 8'hd0);
        wr(pirq_pkg::IDX_CA_MODE, 8'h01);
        wr(pirq_pkg::IDX_MOD_MODE, 8'h1f);
        wr(pirq_pkg::IDX_IRQ_MASK, 8'h07);
        // every source alone: tx, rx, five modules, overflow
        for (int i = 0; i < 8; i++)
        begin
            fire(8'h01 << i, '0);
            settle(20);
            `C({ca_irq, ser_irq, irq}, {i > 1, i < 2, 1'b1})
            rd(pirq_pkg::IDX_IRQ_STAT, (i < 2) ? 9'h002 : 9'h001);
            wr(pirq_pkg::IDX_CA_CTRL, 8'h00);
            wr(pirq_pkg::IDX_SER_CTRL, 8'h00);
            wr(pirq_pkg::IDX_IRQ_CLR, 8'h07);
            settle(3);
            `C({ca_irq, ser_irq, irq}, 3'h0)
        end
        k = seed % 5;
        wr(pirq_pkg::IDX_MOD_MODE, 8'h1f ^ (8'h01 << k));
        fire(8'h04 << k, '0);
        `C(ca_irq, 1'b0)
        rd(pirq_pkg::IDX_CA_CTRL, {1'b0, 8'h01 << k});
        wr(pirq_pkg::IDX_MOD_MODE, 8'h1f);
        settle(3);
        `C(ca_irq, 1'b1)
        wr(pirq_pkg::IDX_CA_CTRL, 8'h00);
        wr(pirq_pkg::IDX_IRQ_CLR, 8'h07);
        wr(pirq_pkg::IDX_IRQ_EN_ZERO, 8'h50);
        wr(pirq_pkg::IDX_IRQ_MASK, 8'h00);
        fire(8'h02, '0);
        `C({ser_irq, irq}, 2'b00)
        wr(pirq_pkg::IDX_IRQ_EN_ZERO, 8'hd0);
        settle(3);
        `C({ser_irq, irq}, 2'b10)
        wr(pirq_pkg::IDX_IRQ_MASK, 8'h07);
        settle(3);
        `C(irq, 1'b1)
        wr(pirq_pkg::IDX_IRQ_CLR, 8'h02);
        rd(pirq_pkg::IDX_IRQ_CLR, 9'h000);
        settle(3);
        `C({ser_irq, irq}, 2'b10)
        wr(pirq_pkg::IDX_SER_CTRL, 8'h00);
        wr(pirq_pkg::IDX_EP_IRQ_EN, 8'hff);
        for (int i = 0; i < 15; i++)
        begin
            wr(pirq_pkg::IDX_EP_CTRL0, tab[i][25:18]);
            wr(pirq_pkg::IDX_EP_IRQ_FLAGS, 8'h00);
            fire(8'h00, tab[i][17:8]);
            rd(pirq_pkg::IDX_EP_IRQ_FLAGS, {1'b0, tab[i][7:0]});
        end
        fl = 8'h00;
        for (int p = 0; p < 4; p++)
        begin
            wr(pirq_pkg::IDX_EP_CTRL0 + 8'(p), 8'h1b);
            fire(8'h00, {1'b1, 2'b10, 2'(p), 5'h10});
            fire(8'h00, {1'b1, 2'b11, 2'(p), 5'h03});
            fl = fl | (8'h03 << 2 * p);
            rd(pirq_pkg::IDX_EP_IRQ_FLAGS, {1'b0, fl});
            `C(fn_irq, 1'b0)
        end
        wr(pirq_pkg::IDX_USB_IRQ_EN, 8'h02);
        settle(3);
        `C(fn_irq, 1'b1)
        seed = lfsr(seed);
        wr(pirq_pkg::IDX_EP_IRQ_EN, 8'h01 << seed[2:0]);
        settle(3);
        `C(fn_irq, 1'b1)
        wr(pirq_pkg::IDX_EP_IRQ_FLAGS, ~(8'h01 << seed[2:0]));
        settle(3);
        `C(fn_irq, 1'b0)
        @(posedge core_clk);
        {sof, sus} <= 2'b11;
        wr(pirq_pkg::IDX_USB_IRQ_EN, 8'h05);
        settle(6);
        `C({sof_irq, sus_irq, fn_irq}, 3'b110)
        wr(pirq_pkg::IDX_IRQ_EN_ZERO, 8'h50);
        settle(3);
        `C({sof_irq, sus_irq}, 2'b00)
        `C(vec_count > 7, 1'b1)
        complete_run();
    end
endmodule // peripheral_irq_request_logic_test

bind pirq_top pirq_top_checker chk (.core_clk(core_clk), .rst_n(rst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .module_event_set(module_event_set),
    .counter_overflow_set(counter_overflow_set), .rx_complete_set(rx_complete_set),
    .tx_complete_set(tx_complete_set), .usb_evt(usb_evt),
    .counter_array_irq(counter_array_irq), .serial_irq(serial_irq),
    .usb_function_irq(usb_function_irq));

/* File: pirq_apb.sv */
// pirq_apb: apb slave front end, one wait state, registered answer
// assumes an apb master on core_clk; decodes to byte address = 4 * index
`timescale 1ns/1ns
module pirq_apb (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // bus
    input wire pirq_pkg::pirq_apb_req_t req,
    output pirq_pkg::pirq_apb_rsp_t rsp,
    // register side
    output logic wr_stb,
    output logic rd_stb,
    output logic [7:0] reg_idx,
    output logic [7:0] wr_data,
    output logic idx_ok,
    input wire logic [7:0] rd_data,
    input wire logic rd_hit
);
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pirq_apb_st_t;

    pirq_apb_st_t st_q;
    pirq_apb_st_t st_d;
    logic access;

    // unaligned or out-of-range addresses answer with pslverr
    assign access = req.psel && req.penable && !st_q.pready;
    assign reg_idx = req.paddr[9:2];
    assign idx_ok = (req.paddr[1:0] == 2'b00) && (req.paddr[11:10] == 2'b00);
    assign wr_stb = access && req.pwrite && idx_ok;
    assign rd_stb = access && !req.pwrite && idx_ok;
    assign wr_data = req.pwdata[7:0];

    always_comb
    begin
        st_d = '0;
        if (access)
        begin
            st_d.pready = 1'b1;
            st_d.pslverr = !(idx_ok && rd_hit);
            st_d.prdata = (!req.pwrite && idx_ok) ? {24'h00_0000, rd_data} : pirq_pkg::RD_ZERO;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign rsp = st_q;
endmodule // pirq_apb

/* File: pirq_core_model.sv */
// pirq_core_model: stand-in for the core interrupt handler
// assumes irq is a level on core_clk; vectoring writes nothing back
`timescale 1ns/1ns
module pirq_core_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // request
    input wire logic irq,
    // vector entries taken
    output int vectors
);
    logic irq_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_q <= 1'b0;
            vectors <= 0;
        end
        else
        begin
            irq_q <= irq;
            // entry only; flags are left for the service routine
            if (irq && !irq_q)
                vectors <= vectors + 1;
        end
    end
endmodule // pirq_core_model

/* File: pirq_pkg.sv */
// pirq_pkg: shared constants, register map and carrier types
// assumes a 32-bit apb master and a single core clock domain
package pirq_pkg;

    // register indexes; the bus byte address is four times the index
    localparam logic [7:0] IDX_EP_IRQ_EN = 8'ha2;
    localparam logic [7:0] IDX_EP_IRQ_FLAGS = 8'hc0;
    localparam logic [7:0] IDX_IRQ_EN_ZERO = 8'ha8;
    localparam logic [7:0] IDX_USB_IRQ_EN = 8'hb1;
    localparam logic [7:0] IDX_CA_CTRL = 8'hd8;
    localparam logic [7:0] IDX_CA_MODE = 8'hd9;
    localparam logic [7:0] IDX_MOD_MODE = 8'hda;
    localparam logic [7:0] IDX_SER_CTRL = 8'h98;
    localparam logic [7:0] IDX_EP_CTRL0 = 8'he0;
    localparam logic [7:0] IDX_IRQ_STAT = 8'hf0;
    localparam logic [7:0] IDX_IRQ_CLR = 8'hf1;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hf2;

    // field positions
    localparam int GLOBAL_EN_BIT = 7;
    localparam int CA_EN_BIT = 6;
    localparam int SER_EN_BIT = 4;
    localparam int FUNC_EN_BIT = 1;
    localparam int SOF_EN_BIT = 0;
    localparam int SR_EN_BIT = 2;
    localparam int CA_OVF_BIT = 7;
    localparam int OVF_EN_BIT = 0;
    localparam int SER_RX_BIT = 0;
    localparam int SER_TX_BIT = 1;
    localparam int EPC_RX_EN_BIT = 0;
    localparam int EPC_RX_ACC_BIT = 1;
    localparam int EPC_RX_STALL_BIT = 2;
    localparam int EPC_TX_EN_BIT = 3;
    localparam int EPC_TX_ACC_BIT = 4;
    localparam int EPC_TX_STALL_BIT = 5;
    localparam int EPC_ISO_BIT = 6;
    localparam int NUM_MODULES = 5;
    localparam int NUM_EP = 4;

    // status register event bits
    localparam int ST_CA = 0;
    localparam int ST_SER = 1;
    localparam int ST_FUNC = 2;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // token kinds from the serial engine
    typedef enum logic [1:0] {PIRQ_TOK_NONE, PIRQ_TOK_SETUP, PIRQ_TOK_OUT, PIRQ_TOK_IN}
        pirq_tok_t;

    // transaction report from the serial engine (one-cycle pulse at end)
    typedef struct packed {
        logic done;
        pirq_tok_t tok;
        logic [1:0] ep;
        logic data_rcvd;
        logic timeout;
        logic seq_err;
        logic tx_loaded;
        logic ack;
    } pirq_usb_evt_t;

    // apb request bundle
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pirq_apb_req_t;

    // apb answer bundle
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pirq_apb_rsp_t;

endpackage

/* File: pirq_sync.sv */
// pirq_sync: two-flop level synchroniser, one per bit
// assumes inputs are quasi-static levels from outside the core domain
`timescale 1ns/1ns
module pirq_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } pirq_sync_st_t;

    pirq_sync_st_t st_q;
    pirq_sync_st_t st_d;

    always_comb
    begin
        st_d.meta = async_in;
        st_d.stable = st_q.meta;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign sync_out = st_q.stable;
endmodule // pirq_sync

/* File: pirq_top.sv */
// pirq_top: peripheral interrupt request aggregation with apb register file
// assumes serial engine events on core_clk; raw peripheral flag sets from logic
`timescale 1ns/1ns
module pirq_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // apb
    input wire pirq_pkg::pirq_apb_req_t apb_req,
    output pirq_pkg::pirq_apb_rsp_t apb_rsp,
    // peripheral event inputs (one-cycle pulses, core domain)
    input wire logic [4:0] module_event_set,
    input wire logic counter_overflow_set,
    input wire logic rx_complete_set,
    input wire logic tx_complete_set,
    input wire pirq_pkg::pirq_usb_evt_t usb_evt,
    // usb side requests from other blocks, asynchronous levels
    input wire logic sof_pending,
    input wire logic suspend_resume_pending,
    // requests to core interrupt handler
    output logic counter_array_irq,
    output logic serial_irq,
    output logic usb_function_irq,
    output logic usb_sof_irq,
    output logic usb_suspend_irq,
    output logic irq
);
    typedef struct packed {
        logic [7:0] irq_en_zero;
        logic [7:0] usb_irq_en;
        logic [7:0] usb_endpoint_irq_enable;
        logic [7:0] usb_endpoint_irq_flags;
        logic [7:0] ca_ctrl;
        logic ca_mode_ovf_en;
        logic [4:0] module_irq_enable;
        logic [1:0] ser_flags;
        logic [6:0] ep_ctrl_0;
        logic [6:0] ep_ctrl_1;
        logic [6:0] ep_ctrl_2;
        logic [6:0] ep_ctrl_3;
        logic [2:0] stat;
        logic [2:0] stat_mask;
        logic ca_irq;
        logic ser_irq;
        logic func_irq;
        logic sof_irq;
        logic sr_irq;
        logic any_irq;
    } pirq_top_st_t;

    pirq_top_st_t st_q;
    pirq_top_st_t st_d;

    logic wr_stb;
    logic rd_stb;
    logic [7:0] reg_idx;
    logic [7:0] wr_data;
    logic idx_ok;
    logic [7:0] rd_data;
    logic rd_hit;
    logic [1:0] async_sync;
    logic [7:0] ep_set;
    logic [6:0] ep_ctrl [pirq_pkg::NUM_EP];
    logic global_on;
    logic ca_req;
    logic ser_req;
    logic func_req;
    logic [2:0] stat_ev;

    pirq_apb u_apb (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .req(apb_req),
        .rsp(apb_rsp),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .reg_idx(reg_idx),
        .wr_data(wr_data),
        .idx_ok(idx_ok),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    // sof and suspend come from other clock-domain logic
    pirq_sync #(.W(2)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in({suspend_resume_pending, sof_pending}),
        .sync_out(async_sync)
    );

    assign ep_ctrl[0] = st_q.ep_ctrl_0;
    assign ep_ctrl[1] = st_q.ep_ctrl_1;
    assign ep_ctrl[2] = st_q.ep_ctrl_2;
    assign ep_ctrl[3] = st_q.ep_ctrl_3;

    // done-flag set conditions per endpoint; bit 2k+1 rx, bit 2k tx
    genvar g;
    generate
        for (g = 0; g < pirq_pkg::NUM_EP; g++)
        begin : g_ep
            logic hit;
            logic rx_ok;
            logic tx_ok;
            assign hit = usb_evt.done && (usb_evt.ep == 2'(g))
                && !ep_ctrl[g][pirq_pkg::EPC_ISO_BIT];
            assign rx_ok = ep_ctrl[g][pirq_pkg::EPC_RX_EN_BIT]
                && ((usb_evt.tok == pirq_pkg::PIRQ_TOK_SETUP)
                || ((usb_evt.tok == pirq_pkg::PIRQ_TOK_OUT)
                && ep_ctrl[g][pirq_pkg::EPC_RX_ACC_BIT]
                && !ep_ctrl[g][pirq_pkg::EPC_RX_STALL_BIT]));
            assign tx_ok = (usb_evt.tok == pirq_pkg::PIRQ_TOK_IN)
                && ep_ctrl[g][pirq_pkg::EPC_TX_EN_BIT]
                && ep_ctrl[g][pirq_pkg::EPC_TX_ACC_BIT]
                && !ep_ctrl[g][pirq_pkg::EPC_TX_STALL_BIT];
            // crc, stuffing and fifo errors are not inputs here on purpose
            assign ep_set[2*g+1] = hit && rx_ok && usb_evt.data_rcvd
                && !usb_evt.timeout && !usb_evt.seq_err;
            assign ep_set[2*g] = hit && tx_ok && usb_evt.tx_loaded
                && (usb_evt.ack || usb_evt.timeout);
        end
    endgenerate

    assign global_on = st_q.irq_en_zero[pirq_pkg::GLOBAL_EN_BIT];
    assign ca_req = st_q.irq_en_zero[pirq_pkg::CA_EN_BIT]
        && (|(st_q.ca_ctrl[4:0] & st_q.module_irq_enable)
        || (st_q.ca_ctrl[pirq_pkg::CA_OVF_BIT] && st_q.ca_mode_ovf_en));
    assign ser_req = st_q.irq_en_zero[pirq_pkg::SER_EN_BIT] && |st_q.ser_flags;
    assign func_req = st_q.usb_irq_en[pirq_pkg::FUNC_EN_BIT]
        && |(st_q.usb_endpoint_irq_flags & st_q.usb_endpoint_irq_enable);
    assign stat_ev = {ep_set != 8'h00, rx_complete_set | tx_complete_set,
        (|module_event_set) | counter_overflow_set};

    // register read mux
    always_comb
    begin
        rd_data = 8'h00;
        rd_hit = 1'b1;
        case (reg_idx)
            pirq_pkg::IDX_IRQ_EN_ZERO: rd_data = st_q.irq_en_zero;
            pirq_pkg::IDX_USB_IRQ_EN: rd_data = {5'b0_0000, st_q.usb_irq_en[2:0]};
            pirq_pkg::IDX_EP_IRQ_EN: rd_data = st_q.usb_endpoint_irq_enable;
            pirq_pkg::IDX_EP_IRQ_FLAGS: rd_data = st_q.usb_endpoint_irq_flags;
            pirq_pkg::IDX_CA_CTRL: rd_data = st_q.ca_ctrl;
            pirq_pkg::IDX_CA_MODE: rd_data = {7'b000_0000, st_q.ca_mode_ovf_en};
            pirq_pkg::IDX_MOD_MODE: rd_data = {3'b000, st_q.module_irq_enable};
            pirq_pkg::IDX_SER_CTRL: rd_data = {6'b00_0000, st_q.ser_flags};
            pirq_pkg::IDX_EP_CTRL0: rd_data = {1'b0, st_q.ep_ctrl_0};
            pirq_pkg::IDX_EP_CTRL0 + 8'h01: rd_data = {1'b0, st_q.ep_ctrl_1};
            pirq_pkg::IDX_EP_CTRL0 + 8'h02: rd_data = {1'b0, st_q.ep_ctrl_2};
            pirq_pkg::IDX_EP_CTRL0 + 8'h03: rd_data = {1'b0, st_q.ep_ctrl_3};
            pirq_pkg::IDX_IRQ_STAT: rd_data = {5'b0_0000, st_q.stat};
            pirq_pkg::IDX_IRQ_CLR: rd_data = 8'h00;
            pirq_pkg::IDX_IRQ_MASK: rd_data = {5'b0_0000, st_q.stat_mask};
            default: rd_hit = 1'b0;
        endcase
    end

    // next state; hardware sets are applied after software writes so set wins
    always_comb
    begin
        st_d = st_q;
        if (wr_stb)
        begin
            case (reg_idx)
                pirq_pkg::IDX_IRQ_EN_ZERO: st_d.irq_en_zero = wr_data;
                pirq_pkg::IDX_USB_IRQ_EN: st_d.usb_irq_en = {5'b0_0000, wr_data[2:0]};
                pirq_pkg::IDX_EP_IRQ_EN: st_d.usb_endpoint_irq_enable = wr_data;
                // software may set or clear flags by writing
                pirq_pkg::IDX_EP_IRQ_FLAGS: st_d.usb_endpoint_irq_flags = wr_data;
                pirq_pkg::IDX_CA_CTRL: st_d.ca_ctrl = wr_data;
                pirq_pkg::IDX_CA_MODE: st_d.ca_mode_ovf_en = wr_data[pirq_pkg::OVF_EN_BIT];
                pirq_pkg::IDX_MOD_MODE: st_d.module_irq_enable = wr_data[4:0];
                pirq_pkg::IDX_SER_CTRL: st_d.ser_flags = wr_data[1:0];
                pirq_pkg::IDX_EP_CTRL0: st_d.ep_ctrl_0 = wr_data[6:0];
                pirq_pkg::IDX_EP_CTRL0 + 8'h01: st_d.ep_ctrl_1 = wr_data[6:0];
                pirq_pkg::IDX_EP_CTRL0 + 8'h02: st_d.ep_ctrl_2 = wr_data[6:0];
                pirq_pkg::IDX_EP_CTRL0 + 8'h03: st_d.ep_ctrl_3 = wr_data[6:0];
                pirq_pkg::IDX_IRQ_CLR: st_d.stat = st_q.stat & ~wr_data[2:0];
                pirq_pkg::IDX_IRQ_MASK: st_d.stat_mask = wr_data[2:0];
                default: st_d.irq_en_zero = st_q.irq_en_zero;
            endcase
        end
        // hardware sets only; no vector acknowledge ever clears a flag
        st_d.ca_ctrl[4:0] = st_d.ca_ctrl[4:0] | module_event_set;
        st_d.ca_ctrl[pirq_pkg::CA_OVF_BIT] = st_d.ca_ctrl[pirq_pkg::CA_OVF_BIT]
            | counter_overflow_set;
        st_d.ser_flags[pirq_pkg::SER_RX_BIT] = st_d.ser_flags[pirq_pkg::SER_RX_BIT]
            | rx_complete_set;
        st_d.ser_flags[pirq_pkg::SER_TX_BIT] = st_d.ser_flags[pirq_pkg::SER_TX_BIT]
            | tx_complete_set;
        st_d.usb_endpoint_irq_flags = st_d.usb_endpoint_irq_flags | ep_set;
        st_d.stat = st_d.stat | stat_ev;
        // outputs registered from current state
        st_d.ca_irq = global_on && ca_req;
        st_d.ser_irq = global_on && ser_req;
        st_d.func_irq = global_on && func_req;
        st_d.sof_irq = global_on && st_q.usb_irq_en[pirq_pkg::SOF_EN_BIT]
            && async_sync[0];
        st_d.sr_irq = global_on && st_q.usb_irq_en[pirq_pkg::SR_EN_BIT] && async_sync[1];
        st_d.any_irq = |(st_q.stat & st_q.stat_mask);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign counter_array_irq = st_q.ca_irq;
    assign serial_irq = st_q.ser_irq;
    assign usb_function_irq = st_q.func_irq;
    assign usb_sof_irq = st_q.sof_irq;
    assign usb_suspend_irq = st_q.sr_irq;
    assign irq = st_q.any_irq;
endmodule // pirq_top

/* File: pirq_top_checker.sv */
// pirq_top_checker: port-level timing and cause checks for pirq_top
// assumes one core_clk domain, rst_n asynchronous active low
`timescale 1ns/1ns
module pirq_top_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // bus
    input wire pirq_pkg::pirq_apb_req_t apb_req,
    input wire pirq_pkg::pirq_apb_rsp_t apb_rsp,
    // events
    input wire logic [4:0] module_event_set,
    input wire logic counter_overflow_set,
    input wire logic rx_complete_set,
    input wire logic tx_complete_set,
    input wire pirq_pkg::pirq_usb_evt_t usb_evt,
    // requests
    input wire logic counter_array_irq,
    input wire logic serial_irq,
    input wire logic usb_function_irq
);
    // short history: a request may only move soon after one of these causes
    logic [2:0] wr_q, ca_q, se_q, fn_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            {wr_q, ca_q, se_q, fn_q} <= 12'h000;
        else
        begin
            wr_q <= {wr_q[1:0], apb_req.psel & apb_req.penable & apb_req.pwrite};
            ca_q <= {ca_q[1:0], (|module_event_set) | counter_overflow_set};
            se_q <= {se_q[1:0], rx_complete_set | tx_complete_set};
            fn_q <= {fn_q[1:0], usb_evt.done};
        end
    end

    ready_wait_a: assert property ((apb_req.psel && !apb_req.penable) ##1
        (apb_req.psel && apb_req.penable) |=> apb_rsp.pready) else $error("pready late");
    ready_once_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready held");
    upper_zero_a: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h00_0000)
        else $error("prdata upper bits set");
    ca_hold_a: assert property ($fell(counter_array_irq) |-> |wr_q)
        else $error("counter array request dropped without write");
    ser_hold_a: assert property ($fell(serial_irq) |-> |wr_q)
        else $error("serial request dropped without write");
    fn_hold_a: assert property ($fell(usb_function_irq) |-> |wr_q)
        else $error("function request dropped without write");
    ca_rise_a: assert property ($rose(counter_array_irq) |-> |{ca_q, wr_q})
        else $error("counter array request without cause");
    ser_rise_a: assert property ($rose(serial_irq) |-> |{se_q, wr_q})
        else $error("serial request without cause");
    fn_rise_a: assert property ($rose(usb_function_irq) |-> |{fn_q, wr_q})
        else $error("function request without cause");
endmodule // pirq_top_checker
